// ---- dpwm_pkg.sv ----
/*
 * dpwm_pkg: shared constants of the dual pwm dac output block.
 * Assumes: the cpu port bus and the pwm generator share one 100 MHz clock.
 */
package dpwm_pkg;

    // ***************************************************************
    // port addresses and selector codes
    // ***************************************************************
    localparam logic [4:0] PORT_R4_ADDR    = 5'h04; // pin output latches
    localparam logic [4:0] SEL_PORT_ADDR   = 5'h17; // pwm_buffer_selector
    localparam logic [4:0] XFER_PORT_ADDR  = 5'h18; // pwm_transfer_buffer_port
    localparam logic [3:0] SEL_RESET       = 4'h0;
    localparam logic [3:0] SEL_FINE_MID    = 4'h2; // fine bits 9..6
    localparam logic [3:0] SEL_FINE_HIGH   = 4'h3; // fine bits 13..10
    localparam logic [3:0] SEL_FINE_LOW    = 4'h4; // fine bits 3..0
    localparam logic [3:0] SEL_FINE_TOP    = 4'h5; // fine bits 5..4
    localparam logic [3:0] SEL_COARSE_LOW  = 4'h6; // coarse bits 3..0
    localparam logic [3:0] SEL_COARSE_HIGH = 4'h7; // coarse bits 5..4
    localparam logic [3:0] SEL_TRANSFER    = 4'hc; // commit code

    // ***************************************************************
    // field layout
    // ***************************************************************
    localparam int FINE_W        = 14;
    localparam int COARSE_W      = 6;
    localparam int FINE_N_LSB    = 6;  // upper 8-bit width field
    localparam int FINE_N_W      = 8;
    localparam int FINE_M_W      = 6;  // lower 6-bit stretch field
    localparam int SUB_W         = 6;  // 64 sub-periods
    localparam int PIN_FINE_BIT  = 0;
    localparam int PIN_COARSE_BIT = 1;
    localparam logic [FINE_W-1:0]   FINE_RESET   = 14'h0000;
    localparam logic [COARSE_W-1:0] COARSE_RESET = 6'h00;
    localparam logic PIN_LATCH_RESET = 1'b1;

    // ***************************************************************
    // timing: fc is the block clock
    // ***************************************************************
    localparam int CLK_PERIOD_NS   = 10;
    localparam int UNIT_CYC        = 2;     // one pulse unit is 2/fc
    localparam int FINE_SUB_CYC    = 512;   // one sub-period
    localparam int FINE_MAIN_CYC   = 32768; // one main period
    localparam int COARSE_MAIN_CYC = 128;
    localparam int FINE_UNITS      = FINE_SUB_CYC / UNIT_CYC;     // 256
    localparam int COARSE_UNITS    = COARSE_MAIN_CYC / UNIT_CYC;  // 64
    localparam logic [FINE_N_W-1:0] FINE_UNIT_LAST   = 8'(FINE_UNITS - 1);
    localparam logic [COARSE_W-1:0] COARSE_UNIT_LAST = 6'(COARSE_UNITS - 1);
    localparam logic [SUB_W-1:0]    SUB_LAST         = 6'(FINE_MAIN_CYC / FINE_SUB_CYC - 1);
    localparam logic PRESCALE_LAST = 1'(UNIT_CYC - 1);

endpackage

// ---- dpwm_data_if.sv ----
/*
 * dpwm_data_if: committed pwm data latches passed from the port
 * register module to the waveform generator.
 * Assumes: both ends run on the same clock.
 */
`timescale 1ns/10ps
interface dpwm_data_if;
    logic [13:0] fine_data;   // committed fine channel value
    logic [5:0]  coarse_data; // committed coarse channel value
    logic        enabled;     // a transfer has been made since the last reset or hold

    modport src (output fine_data, output coarse_data, output enabled);
    modport dst (input fine_data, input coarse_data, input enabled);
endinterface

// ---- dpwm_xfer_regs.sv ----
/*
 * dpwm_xfer_regs: buffer selector, transfer buffer and pwm data latches.
 * Assumes: single-cycle write strobes from the cpu port logic, same clock.
 */
`timescale 1ns/10ps
module dpwm_xfer_regs (
    input  wire logic       ref_clk_in,   // 100 MHz clock
    input  wire logic       reset_in,     // sync reset, active high
    input  wire logic       hold_in,      // hold entry, clears like reset
    input  wire logic       port_wr_in,   // port write strobe
    input  wire logic [4:0] port_addr_in, // port address
    input  wire logic [3:0] port_data_in, // port write data
    dpwm_data_if.src        data_if       // committed latches
);
    logic [3:0]  sel_reg,      sel_next;
    logic [13:0] fbuf_reg,     fbuf_next;
    logic [5:0]  cbuf_reg,     cbuf_next;
    logic [13:0] flatch_reg,   flatch_next;
    logic [5:0]  clatch_reg,   clatch_next;
    logic        enabled_reg,  enabled_next;

    // ***************************************************************
    // selector decode and buffer fill
    // ***************************************************************
    always_comb begin
        sel_next     = sel_reg;
        fbuf_next    = fbuf_reg;
        cbuf_next    = cbuf_reg;
        flatch_next  = flatch_reg;
        clatch_next  = clatch_reg;
        enabled_next = enabled_reg;
        if (port_wr_in && port_addr_in == dpwm_pkg::SEL_PORT_ADDR) begin
            sel_next = port_data_in;
            // commit is immediate; generator reloads at its period edge
            if (port_data_in == dpwm_pkg::SEL_TRANSFER) begin
                flatch_next  = fbuf_reg;
                clatch_next  = cbuf_reg;
                enabled_next = 1'b1;
            end
        end
        if (port_wr_in && port_addr_in == dpwm_pkg::XFER_PORT_ADDR) begin
            // other selector values leave the buffer untouched
            case (sel_reg)
                dpwm_pkg::SEL_FINE_MID:    fbuf_next[9:6]   = port_data_in;
                dpwm_pkg::SEL_FINE_HIGH:   fbuf_next[13:10] = port_data_in;
                dpwm_pkg::SEL_FINE_LOW:    fbuf_next[3:0]   = port_data_in;
                dpwm_pkg::SEL_FINE_TOP:    fbuf_next[5:4]   = port_data_in[1:0];
                dpwm_pkg::SEL_COARSE_LOW:  cbuf_next[3:0]   = port_data_in;
                dpwm_pkg::SEL_COARSE_HIGH: cbuf_next[5:4]   = port_data_in[1:0];
                default: ;
            endcase
        end
    end

    // latches change only on commit; reset and hold clear all
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || hold_in) begin
            sel_reg     <= dpwm_pkg::SEL_RESET;
            fbuf_reg    <= dpwm_pkg::FINE_RESET;
            cbuf_reg    <= dpwm_pkg::COARSE_RESET;
            flatch_reg  <= dpwm_pkg::FINE_RESET;
            clatch_reg  <= dpwm_pkg::COARSE_RESET;
            enabled_reg <= 1'b0;
        end else begin
            sel_reg     <= sel_next;
            fbuf_reg    <= fbuf_next;
            cbuf_reg    <= cbuf_next;
            flatch_reg  <= flatch_next;
            clatch_reg  <= clatch_next;
            enabled_reg <= enabled_next;
        end
    end

    assign data_if.fine_data   = flatch_reg;
    assign data_if.coarse_data = clatch_reg;
    assign data_if.enabled     = enabled_reg;
endmodule

// ---- dpwm_dac_output.sv ----
/*
 * dpwm_dac_output: two-channel pwm dac output, a 14-bit fine channel with
 * sub-period stretching and a 6-bit coarse channel, plus their pin latches.
 * Assumes: cpu port writes arrive as one-cycle strobes on ref_clk_in;
 * external open-drain pads and low-pass filters sit outside.
 */
`timescale 1ns/10ps
module dpwm_dac_output (
    input  wire logic       ref_clk_in,             // 100 MHz clock
    input  wire logic       reset_in,               // sync reset, active high
    input  wire logic       hold_in,                // hold entry, active high
    input  wire logic       port_wr_in,             // cpu port write strobe
    input  wire logic [4:0] port_addr_in,           // cpu port address
    input  wire logic [3:0] port_data_in,           // cpu port write data
    output logic            fine_pwm_output_out,    // fine channel level
    output logic            coarse_pwm_output_out,  // coarse channel level
    output logic            fine_pwm_port_pin_out,  // fine pad data, always low
    output logic            fine_pwm_port_pin_oe_n_out,   // fine pad pull-down, low = drive
    output logic            coarse_pwm_port_pin_out,      // coarse pad data, always low
    output logic            coarse_pwm_port_pin_oe_n_out  // coarse pad pull-down, low = drive
);

    dpwm_data_if data_if ();

    // ***************************************************************
    // port registers
    // ***************************************************************
    dpwm_xfer_regs u_xfer_regs (
        .ref_clk_in   (ref_clk_in),
        .reset_in     (reset_in),
        .hold_in      (hold_in),
        .port_wr_in   (port_wr_in),
        .port_addr_in (port_addr_in),
        .port_data_in (port_data_in),
        .data_if      (data_if)
    );

    // ***************************************************************
    // helpers
    // ***************************************************************
    // stretch weight j lands where sub index has its lowest set bit at 5-j
    // sub 0 has no set bit and is never stretched; spreading the extra units
    // keeps the ripple at the sub-period rate instead of the main period
    function automatic logic stretch_hit(input logic [5:0] m, input logic [5:0] sub);
        logic hit;
        logic lower_zero;
        hit = 1'b0;
        lower_zero = 1'b1;
        for (int k = 0; k < dpwm_pkg::SUB_W; k++) begin
            if (lower_zero && sub[k] && m[dpwm_pkg::SUB_W-1-k]) begin
                hit = 1'b1;
            end
            if (sub[k]) begin
                lower_zero = 1'b0;
            end
        end
        return hit;
    endfunction

    // pin level: high unless the pulse is running and the latch lets it through
    function automatic logic pin_level(input logic latch, input logic en, input logic pulse);
        return ~(en & pulse) | ~latch;
    endfunction

    // ***************************************************************
    // state
    // ***************************************************************
    logic                 prescale_reg,  prescale_next;
    logic [7:0]           funit_reg,     funit_next;
    logic [5:0]           fsub_reg,      fsub_next;
    logic [5:0]           cunit_reg,     cunit_next;
    logic [13:0]          fwork_reg,     fwork_next;
    logic [5:0]           cwork_reg,     cwork_next;
    logic                 en_reg,        en_next;
    logic [1:0]           pin_latch_reg, pin_latch_next;
    logic                 flevel_reg,    flevel_next;
    logic                 clevel_reg,    clevel_next;
    logic                 unit_end;
    logic                 fine_wrap;
    logic                 coarse_wrap;
    logic                 fine_pulse;
    logic                 coarse_pulse;
    logic [8:0]           fine_width;

    // ***************************************************************
    // timebase
    // ***************************************************************
    // coarse unit count and the low fine unit bits step together, so a
    // coarse wrap always lands on a fine unit edge
    // unit ends every second clock; sub-periods are 256 units
    always_comb begin
        unit_end    = (prescale_reg == dpwm_pkg::PRESCALE_LAST);
        fine_wrap   = unit_end && funit_reg == dpwm_pkg::FINE_UNIT_LAST
                      && fsub_reg == dpwm_pkg::SUB_LAST;
        coarse_wrap = unit_end && cunit_reg == dpwm_pkg::COARSE_UNIT_LAST;
        prescale_next = ~prescale_reg;
        funit_next    = funit_reg;
        fsub_next     = fsub_reg;
        cunit_next    = cunit_reg;
        if (unit_end) begin
            funit_next = funit_reg + 8'h01; // wraps at 256 units
            cunit_next = cunit_reg + 6'h01; // wraps at 64 units, 128 clocks
            if (funit_reg == dpwm_pkg::FINE_UNIT_LAST) begin
                fsub_next = fsub_reg + 6'h01;
            end
        end
    end

    // ***************************************************************
    // working copies and pin latches
    // ***************************************************************
    // working copies reload only at period boundaries so a period never
    // mixes old and new data; worst case wait is one full period
    // enable follows the coarse wrap, so the fine channel can only start
    // mid sub-period while its working copy is still zero
    always_comb begin
        fwork_next     = fwork_reg;
        cwork_next     = cwork_reg;
        en_next        = en_reg;
        pin_latch_next = pin_latch_reg;
        if (fine_wrap) begin
            fwork_next = data_if.fine_data;
        end
        if (coarse_wrap) begin
            cwork_next = data_if.coarse_data;
            en_next    = data_if.enabled;
        end
        if (port_wr_in && port_addr_in == dpwm_pkg::PORT_R4_ADDR) begin
            pin_latch_next = port_data_in[1:0];
        end
    end

    // ***************************************************************
    // pulse generation
    // ***************************************************************
    // pulse width is n units plus one when this sub-period is stretched
    // nine bits so n of 255 plus a stretch unit reaches 256 units, a pulse
    // that fills the whole sub-period
    always_comb begin
        fine_width = {1'b0, fwork_reg[13:dpwm_pkg::FINE_N_LSB]}
                     + {8'h00, stretch_hit(fwork_reg[5:0], fsub_reg)};
        fine_pulse   = {1'b0, funit_reg} < fine_width;
        coarse_pulse = cunit_reg < cwork_reg;
        // low during pulse, high otherwise; zero data never goes low
        flevel_next = pin_level(pin_latch_reg[dpwm_pkg::PIN_FINE_BIT], en_reg, fine_pulse);
        clevel_next = pin_level(pin_latch_reg[dpwm_pkg::PIN_COARSE_BIT], en_reg, coarse_pulse);
    end

    // ***************************************************************
    // registers
    // ***************************************************************
    // hold clears the data path like reset; pin latches only on reset
    // a cleared pin latch forces the level high, so the pad floats to its
    // pull-up and the filter settles at the idle level
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            pin_latch_reg <= {2{dpwm_pkg::PIN_LATCH_RESET}};
        end else begin
            pin_latch_reg <= pin_latch_next;
        end
    end

    // counters and working copies restart cleanly on hold release
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || hold_in) begin
            prescale_reg <= 1'b0;
            funit_reg    <= 8'h00;
            fsub_reg     <= 6'h00;
            cunit_reg    <= 6'h00;
            fwork_reg    <= dpwm_pkg::FINE_RESET;
            cwork_reg    <= dpwm_pkg::COARSE_RESET;
            en_reg       <= 1'b0;
            flevel_reg   <= 1'b1;
            clevel_reg   <= 1'b1;
        end else begin
            prescale_reg <= prescale_next;
            funit_reg    <= funit_next;
            fsub_reg     <= fsub_next;
            cunit_reg    <= cunit_next;
            fwork_reg    <= fwork_next;
            cwork_reg    <= cwork_next;
            en_reg       <= en_next;
            flevel_reg   <= flevel_next;
            clevel_reg   <= clevel_next;
        end
    end

    // ***************************************************************
    // pins
    // ***************************************************************
    // open-drain pads: data is always low, enable pulls the wire low
    // only while the level is low, so the wire floats high otherwise
    // the pad data flop is constant, kept so every output leaves a register
    logic pad_zero_reg;
    always_ff @(posedge ref_clk_in) begin
        pad_zero_reg <= 1'b0;
    end

    assign fine_pwm_output_out          = flevel_reg;
    assign coarse_pwm_output_out        = clevel_reg;
    assign fine_pwm_port_pin_out        = pad_zero_reg;
    assign coarse_pwm_port_pin_out      = pad_zero_reg;
    assign fine_pwm_port_pin_oe_n_out   = flevel_reg;
    assign coarse_pwm_port_pin_oe_n_out = clevel_reg;

endmodule

// ---- dpwm_props.sv ----
/* dpwm_props: concurrent checks on the dual pwm outputs.
   Assumes: bound to dpwm_dac_output; one clock, synchronous reset. */
`timescale 1ns/10ps
module dpwm_props (
    input wire logic       ref_clk_in,                  // clock
    input wire logic       reset_in,                    // sync reset
    input wire logic       hold_in,                     // hold entry
    input wire logic       port_wr_in,                  // write strobe
    input wire logic [4:0] port_addr_in,                // address
    input wire logic [3:0] port_data_in,                // nibble
    input wire logic       fine_pwm_output_out,         // fine level
    input wire logic       coarse_pwm_output_out,       // coarse level
    input wire logic       fine_pwm_port_pin_out,       // fine pad data
    input wire logic       fine_pwm_port_pin_oe_n_out,  // fine pad enable
    input wire logic       coarse_pwm_port_pin_out,     // coarse pad data
    input wire logic       coarse_pwm_port_pin_oe_n_out // coarse pad enable
);
    // ********
    // helper state
    // ********
    logic        clr, fl, cl, on_reg, on_next, fp_reg, cp_reg;
    logic        fs_reg, fs_next, cs_reg, cs_next;
    logic [1:0]  lat_reg, lat_next;
    logic [15:0] fc_reg, fc_next, cc_reg, cc_next;
    assign clr = reset_in | hold_in;
    assign fl  = fine_pwm_output_out;
    assign cl  = coarse_pwm_output_out;
    // cycles since each falling level; a cleared pin latch voids the
    // history because a forced level breaks the pulse pattern
    always_comb begin
        lat_next = reset_in ? 2'h3 : lat_reg;
        on_next  = on_reg & ~clr;
        if (port_wr_in && port_addr_in == dpwm_pkg::PORT_R4_ADDR && !reset_in) begin
            lat_next = port_data_in[1:0];
        end
        if (port_wr_in && port_addr_in == dpwm_pkg::SEL_PORT_ADDR
                && port_data_in == dpwm_pkg::SEL_TRANSFER) begin
            on_next = ~clr;
        end
        fc_next = (fp_reg && !fl) ? 16'h0001 : fc_reg + 16'h0001;
        cc_next = (cp_reg && !cl) ? 16'h0001 : cc_reg + 16'h0001;
        fs_next = (fs_reg | (fp_reg & ~fl)) & ~clr & (&lat_reg);
        cs_next = (cs_reg | (cp_reg & ~cl)) & ~clr & (&lat_reg);
    end
    always_ff @(posedge ref_clk_in) begin
        lat_reg <= lat_next;
        on_reg  <= on_next;
        fp_reg  <= fl;
        cp_reg  <= cl;
        fc_reg  <= fc_next;
        cc_reg  <= cc_next;
        fs_reg  <= fs_next;
        cs_reg  <= cs_next;
    end
    default clocking dc @(posedge ref_clk_in);
    endclocking
    default disable iff (clr);
    property p_clear_high;
        disable iff (1'b0) clr |=> fl && cl && fine_pwm_port_pin_oe_n_out
            && coarse_pwm_port_pin_oe_n_out;
    endproperty
    property p_pin_low;
        !fine_pwm_port_pin_out && !coarse_pwm_port_pin_out;
    endproperty
    property p_oe_level;
        (fine_pwm_port_pin_oe_n_out || !fl) && (coarse_pwm_port_pin_oe_n_out || !cl);
    endproperty
    property p_idle_high;
        !on_reg |-> fl && cl;
    endproperty
    property p_fine_fall;
        $fell(fl) && fs_reg && &lat_reg |-> fc_reg[8:0] == 9'h000;
    endproperty
    property p_fine_rise;
        $rose(fl) && fs_reg && &lat_reg |-> !fc_reg[0];
    endproperty
    property p_coarse_fall;
        $fell(cl) && cs_reg && &lat_reg |-> cc_reg[6:0] == 7'h00;
    endproperty
    property p_coarse_rise;
        $rose(cl) && cs_reg && &lat_reg |-> !cc_reg[0] && cc_reg <= 16'd126;
    endproperty
    property p_latch_gate;
        (!lat_reg[0] |=> fl) and (!lat_reg[1] |=> cl);
    endproperty
    property p_coarse_unit;
        $changed(cl) && &lat_reg && !port_wr_in |=> $stable(cl);
    endproperty
    a_clear_high: assert property (p_clear_high)
        else $error("level or enable not high after clear");
    a_pin_low: assert property (p_pin_low)
        else $error("pad data not low");
    a_oe_level: assert property (p_oe_level)
        else $error("pad pulled low while level high");
    a_latch_gate: assert property (p_latch_gate)
        else $error("pwm passed a cleared pin latch");
    a_idle_high: assert property (p_idle_high)
        else $error("output active before commit");
    a_fine_fall: assert property (p_fine_fall)
        else $error("fine pulse off sub-period grid");
    a_fine_rise: assert property (p_fine_rise)
        else $error("fine pulse not whole units");
    a_coarse_fall: assert property (p_coarse_fall)
        else $error("coarse pulse off period grid");
    a_coarse_rise: assert property (p_coarse_rise)
        else $error("coarse pulse length wrong");
    a_coarse_unit: assert property (p_coarse_unit)
        else $error("coarse level held one cycle");
    c_fine_pulse: cover property ($rose(fl) && fs_reg);
    c_coarse_pulse: cover property ($rose(cl) && cs_reg);
    c_hold_run: cover property (disable iff (1'b0) hold_in && on_reg);
endmodule

// ---- dpwm_lpf_model.sv ----
/* dpwm_lpf_model: external low-pass filter on one pwm pad, modelled as a
   moving count of high cycles over the last 128 clocks.
   Assumes: pad level resolved by the bench, sampled on the block clock. */
`timescale 1ns/10ps
module dpwm_lpf_model (
    input  wire logic       clk_in,  // sample clock
    input  wire logic       pad_in,  // resolved pad level
    output logic      [7:0] avg_out  // high cycles in window
);
    logic [127:0] hist_reg = '1;
    // a window of one coarse period makes the count phase independent
    always_ff @(posedge clk_in) begin
        hist_reg <= {hist_reg[126:0], pad_in};
    end
    assign avg_out = 8'($countones(hist_reg));
endmodule

// ---- dpwm_tb.sv ----
/* testbench: self-checking bench for the dual pwm dac output block.
   Assumes: dpwm_props and dpwm_lpf_model are compiled before it. */
`timescale 1ns/10ps
module testbench;
    logic        ref_clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        hold_in = 1'b0;
    logic        port_wr_in = 1'b0;
    logic [4:0]  port_addr_in = 5'h00;
    logic [3:0]  port_data_in = 4'h0;
    logic        f_lvl, c_lvl, f_pin, c_pin, f_oe_n, c_oe_n, fp, cp;
    logic [7:0]  f_avg, c_avg, rnd;
    logic [15:0] fq[$], cq[$];
    logic [13:0] fv;
    logic [5:0]  k1, k2;
    logic [3:0]  junk[4] = '{4'h0, 4'h1, 4'h8, 4'hf};
    logic [5:0]  edge_k[2] = '{6'h00, 6'h3f};
    int          miscompares, checks_done, tcnt, cyc, ff, cf;
    always #5 ref_clk_in = ~ref_clk_in;
    dpwm_dac_output dut (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .hold_in(hold_in),
        .port_wr_in(port_wr_in), .port_addr_in(port_addr_in), .port_data_in(port_data_in),
        .fine_pwm_output_out(f_lvl), .coarse_pwm_output_out(c_lvl),
        .fine_pwm_port_pin_out(f_pin), .fine_pwm_port_pin_oe_n_out(f_oe_n),
        .coarse_pwm_port_pin_out(c_pin), .coarse_pwm_port_pin_oe_n_out(c_oe_n));
    // open-drain pads with pull-ups: a released pad reads high
    dpwm_lpf_model u_flpf (.clk_in(ref_clk_in), .pad_in(f_oe_n ? 1'b1 : f_pin), .avg_out(f_avg));
    dpwm_lpf_model u_clpf (.clk_in(ref_clk_in), .pad_in(c_oe_n ? 1'b1 : c_pin), .avg_out(c_avg));
    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s exp %0d got %0d", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ********
    // monitor: pulse widths against the oldest note
    // ********
    always @(posedge ref_clk_in) begin
        tcnt = (reset_in || hold_in) ? 0 : tcnt + 1;
        if (fp && !f_lvl) ff = tcnt;
        if (cp && !c_lvl) cf = tcnt;
        if (!fp && f_lvl && fq.size() > 0 && fq[0][15:10] == 6'((ff + 16) >> 9)) begin
            cmp("fine_width", {6'h00, fq[0][9:0]}, 16'(tcnt - ff));
            void'(fq.pop_front());
        end
        if (!cp && c_lvl && cq.size() > 0) begin
            cmp("coarse_width", cq[0], 16'(tcnt - cf));
            void'(cq.pop_front());
        end
        fp = f_lvl;
        cp = c_lvl;
        cyc++;
        if (cyc == 80000) begin
            miscompares++;
            $display("[ERR] cycles exp below 80000 got %0d", cyc);
            end_sim();
        end
    end
    // ********
    // driver tasks
    // ********
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // stretch bit j lands where the lowest set bit of the index is 5-j
    function automatic logic [9:0] fw(input int i);
        int b;
        b = 0;
        while (i != 0 && !i[b]) b++;
        return {1'b0, fv[13:6], 1'b0} + ((i != 0 && fv[5 - b]) ? 10'h002 : 10'h000);
    endfunction
    task automatic waitc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    task automatic wr(input logic [4:0] a, input logic [3:0] d);
        @(posedge ref_clk_in);
        #1;
        port_wr_in = 1'b1;
        port_addr_in = a;
        port_data_in = d;
        @(posedge ref_clk_in);
        #1;
        port_wr_in = 1'b0;
    endtask
    task automatic put(input logic [3:0] s, input logic [3:0] d);
        wr(dpwm_pkg::SEL_PORT_ADDR, s);
        wr(dpwm_pkg::XFER_PORT_ADDR, d);
    endtask
    // every section in turn, then the commit code
    task automatic load(input logic [5:0] k);
        put(dpwm_pkg::SEL_FINE_MID, fv[9:6]);
        put(dpwm_pkg::SEL_FINE_HIGH, fv[13:10]);
        put(dpwm_pkg::SEL_FINE_LOW, fv[3:0]);
        put(dpwm_pkg::SEL_FINE_TOP, {2'h0, fv[5:4]});
        put(dpwm_pkg::SEL_COARSE_LOW, k[3:0]);
        put(dpwm_pkg::SEL_COARSE_HIGH, {2'h0, k[5:4]});
        wr(dpwm_pkg::SEL_PORT_ADDR, dpwm_pkg::SEL_TRANSFER);
    endtask
    // reload comes within one period, so 300 clocks leaves a clean window
    task automatic note_c(input logic [5:0] k);
        waitc(300);
        cmp("coarse_avg", 16'(128 - 2 * k), {8'h00, c_avg});
        if (k != 6'h00) begin
            cq.push_back(16'(2 * k));
            cq.push_back(16'(2 * k));
        end
        waitc(300);
        cmp("coarse_left", 16'h0000, 16'(cq.size()));
    endtask
    initial begin
        rnd = 8'h13;
        waitc(6);
        #1;
        reset_in = 1'b0;
        waitc(200);
        cmp("fine_avg", 16'h0080, {8'h00, f_avg});
        cmp("coarse_avg", 16'h0080, {8'h00, c_avg});
        $display("test idle done");
        rnd = lfsr(rnd);
        fv[13:8] = {1'b0, rnd[4:0]};
        rnd = lfsr(rnd);
        fv[7:0] = rnd;
        rnd = lfsr(rnd);
        k1 = rnd[5:0] | 6'h01;
        rnd = lfsr(rnd);
        k2 = {k1[5:4], rnd[3:0]};
        load(k1);
        note_c(k1);
        $display("test commit done");
        put(dpwm_pkg::SEL_COARSE_LOW, k2[3:0]);
        note_c(k1);
        $display("test fill done");
        foreach (junk[i]) put(junk[i], 4'hf);
        wr(5'h1f, 4'h5);
        wr(dpwm_pkg::SEL_PORT_ADDR, dpwm_pkg::SEL_TRANSFER);
        note_c(k2);
        $display("test stray done");
        foreach (edge_k[i]) begin
            load(edge_k[i]);
            note_c(edge_k[i]);
        end
        $display("test coarse edges done");
        // start just before a main wrap so sub-period 0 is the first pulse seen
        wait (tcnt > dpwm_pkg::FINE_MAIN_CYC - 100);
        for (int i = 0; i < 64; i++) begin
            if (fw(i) != 10'h000) fq.push_back({6'(i), fw(i)});
        end
        waitc(33000);
        cmp("fine_left", 16'h0000, 16'(fq.size()));
        $display("test fine done");
        @(posedge ref_clk_in);
        #1;
        hold_in = 1'b1;
        waitc(3);
        #1;
        hold_in = 1'b0;
        wr(dpwm_pkg::SEL_PORT_ADDR, dpwm_pkg::SEL_TRANSFER);
        waitc(300);
        cmp("fine_avg", 16'h0080, {8'h00, f_avg});
        cmp("coarse_avg", 16'h0080, {8'h00, c_avg});
        $display("test hold done");
        load(6'h10);
        note_c(6'h10);
        wr(dpwm_pkg::PORT_R4_ADDR, 4'h0);
        waitc(200);
        cmp("coarse_avg", 16'h0080, {8'h00, c_avg});
        $display("test pin latch done");
        end_sim();
    end
endmodule
bind dpwm_dac_output dpwm_props u_props (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .hold_in(hold_in),
    .port_wr_in(port_wr_in), .port_addr_in(port_addr_in), .port_data_in(port_data_in),
    .fine_pwm_output_out(fine_pwm_output_out), .coarse_pwm_output_out(coarse_pwm_output_out),
    .fine_pwm_port_pin_out(fine_pwm_port_pin_out),
    .fine_pwm_port_pin_oe_n_out(fine_pwm_port_pin_oe_n_out),
    .coarse_pwm_port_pin_out(coarse_pwm_port_pin_out),
    .coarse_pwm_port_pin_oe_n_out(coarse_pwm_port_pin_oe_n_out));
